// File: bpo_port.sv
module bpo_port #(
    parameter int PORT_WIDTH = 8,
    parameter bit LARGE_PACKAGE = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // ----------------------------------------
    // Port C pads
    // ----------------------------------------
    input wire logic [7:0] portCIn,
    output logic [7:0] portCOut,
    output logic [7:0] portCOe,
    output logic [7:0] portCTwoWireBuf,
    // ----------------------------------------
    // Second port pads
    // ----------------------------------------
    input wire logic [PORT_WIDTH-1:0] secondPortIn,
    output logic [PORT_WIDTH-1:0] secondPortOut,
    output logic [PORT_WIDTH-1:0] secondPortOe,
    output logic [PORT_WIDTH-1:0] secondPortPullupEn,
    output logic [PORT_WIDTH-1:0] secondPortTtlBuf,
    // ----------------------------------------
    // Serial unit 1
    // ----------------------------------------
    input wire logic ser1SpiEn,
    input wire logic ser1TwoWireEn,
    input wire logic ser1TwoWireSmbus,
    input wire logic ser1SpiClkOut,
    input wire logic ser1SpiDataOut,
    input wire logic ser1TwoWireClkOut,
    input wire logic ser1TwoWireDataOut,
    output logic ser1ClkIn,
    output logic ser1DataIn,
    // ----------------------------------------
    // Serial unit 2
    // ----------------------------------------
    input wire logic ser2SpiEn,
    input wire logic ser2SpiClkOut,
    input wire logic ser2SpiDataOut,
    output logic ser2ClkIn,
    output logic ser2DataIn,
    // ----------------------------------------
    // Receiver-transmitter
    // ----------------------------------------
    input wire logic uartTxDrive,
    input wire logic uartTxOut,
    input wire logic uartDataDrive,
    input wire logic uartDataOut,
    output logic uartClkIn,
    output logic uartRxIn,
    // ----------------------------------------
    // External memory bus and slave port
    // ----------------------------------------
    input wire logic extBusDrive,
    input wire logic [PORT_WIDTH-1:0] extBusOut,
    output logic [PORT_WIDTH-1:0] extBusIn,
    input wire logic pspDrive,
    input wire logic [PORT_WIDTH-1:0] pspOut,
    output logic [PORT_WIDTH-1:0] pspIn
);
    if (PORT_WIDTH != 8) begin : g_bad_width
        $error("PORT_WIDTH must be 8");
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [1:0] padDrive(input logic val, input logic od);
        padDrive = od ? {~val, 1'b0} : {1'b1, val};
    endfunction : padDrive

    function automatic logic [7:0] mergeByte(input logic [7:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
        mergeByte = strb[0] ? data[7:0] : old;
    endfunction : mergeByte

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] cLat_ff;
    logic [7:0] cDir_ff;
    logic [7:0] dLat_ff;
    logic [7:0] dDir_ff;
    logic [7:0] padCfg_ff;
    logic [7:0] memCtl_ff;
    logic [7:0] eDir_ff;
    logic [7:0] odA_ff;
    logic [7:0] odB_ff;
    logic [7:0] cPin_ff;
    logic [7:0] dPin_ff;
    logic [5:0] awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic awHave_ff;
    logic wHave_ff;
    logic [1:0] nxt_bresp;
    logic [31:0] nxt_rdata;
    logic [1:0] nxt_rresp;
    logic doWrite;
    logic [7:0] nxt_cOut;
    logic [7:0] nxt_cOe;
    logic [7:0] nxt_dOut;
    logic [7:0] nxt_dOe;

    assign doWrite = awHave_ff && wHave_ff && !s_axi_bvalid;

    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            awHave_ff <= 1'b0;
            s_axi_awready <= 1'b0;
            awAddr_ff <= 6'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHave_ff <= 1'b1;
            s_axi_awready <= 1'b0;
            awAddr_ff <= s_axi_awaddr;
        end else if (doWrite) begin
            awHave_ff <= 1'b0;
        end else begin
            s_axi_awready <= !awHave_ff && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wHave_ff <= 1'b0;
            s_axi_wready <= 1'b0;
            wData_ff <= 32'h0;
            wStrb_ff <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHave_ff <= 1'b1;
            s_axi_wready <= 1'b0;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
        end else if (doWrite) begin
            wHave_ff <= 1'b0;
        end else begin
            s_axi_wready <= !wHave_ff && !s_axi_bvalid;
        end
    end

    always_comb begin
        unique case (awAddr_ff)
            bpo_pkg::OFS_C_PIN, bpo_pkg::OFS_C_LAT, bpo_pkg::OFS_C_DIR, bpo_pkg::OFS_D_PIN,
            bpo_pkg::OFS_D_LAT, bpo_pkg::OFS_D_DIR, bpo_pkg::OFS_PAD_CFG, bpo_pkg::OFS_MEM_CTL,
            bpo_pkg::OFS_E_DIR, bpo_pkg::OFS_OD_A, bpo_pkg::OFS_OD_B: nxt_bresp = bpo_pkg::RESP_OKAY;
            default: nxt_bresp = bpo_pkg::RESP_SLVERR;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= bpo_pkg::RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= nxt_bresp;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cLat_ff <= bpo_pkg::RST_LAT;
            cDir_ff <= bpo_pkg::RST_DIR;
            dLat_ff <= bpo_pkg::RST_LAT;
            dDir_ff <= bpo_pkg::RST_DIR;
            padCfg_ff <= bpo_pkg::RST_PAD_CFG;
            memCtl_ff <= bpo_pkg::RST_MEM_CTL;
            eDir_ff <= bpo_pkg::RST_E_DIR;
            odA_ff <= bpo_pkg::RST_OD;
            odB_ff <= bpo_pkg::RST_OD;
        end else if (doWrite) begin
            unique case (awAddr_ff)
                bpo_pkg::OFS_C_PIN, bpo_pkg::OFS_C_LAT: cLat_ff <= mergeByte(cLat_ff, wData_ff, wStrb_ff);
                bpo_pkg::OFS_C_DIR: cDir_ff <= mergeByte(cDir_ff, wData_ff, wStrb_ff);
                bpo_pkg::OFS_D_PIN, bpo_pkg::OFS_D_LAT: dLat_ff <= mergeByte(dLat_ff, wData_ff, wStrb_ff);
                bpo_pkg::OFS_D_DIR: dDir_ff <= mergeByte(dDir_ff, wData_ff, wStrb_ff);
                bpo_pkg::OFS_PAD_CFG: padCfg_ff <= mergeByte(padCfg_ff, wData_ff, wStrb_ff);
                bpo_pkg::OFS_MEM_CTL: memCtl_ff <= mergeByte(memCtl_ff, wData_ff, wStrb_ff);
                bpo_pkg::OFS_E_DIR: eDir_ff <= mergeByte(eDir_ff, wData_ff, wStrb_ff);
                bpo_pkg::OFS_OD_A: odA_ff <= mergeByte(odA_ff, wData_ff, wStrb_ff);
                bpo_pkg::OFS_OD_B: odB_ff <= mergeByte(odB_ff, wData_ff, wStrb_ff);
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    always_comb begin
        nxt_rdata = 32'h0;
        nxt_rresp = bpo_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
            bpo_pkg::OFS_C_PIN: nxt_rdata[7:0] = cPin_ff;
            bpo_pkg::OFS_C_LAT: nxt_rdata[7:0] = cLat_ff;
            bpo_pkg::OFS_C_DIR: nxt_rdata[7:0] = cDir_ff;
            bpo_pkg::OFS_D_PIN: nxt_rdata[7:0] = dPin_ff;
            bpo_pkg::OFS_D_LAT: nxt_rdata[7:0] = dLat_ff;
            bpo_pkg::OFS_D_DIR: nxt_rdata[7:0] = dDir_ff;
            bpo_pkg::OFS_PAD_CFG: nxt_rdata[7:0] = padCfg_ff;
            bpo_pkg::OFS_MEM_CTL: nxt_rdata[7:0] = memCtl_ff;
            bpo_pkg::OFS_E_DIR: nxt_rdata[7:0] = eDir_ff;
            bpo_pkg::OFS_OD_A: nxt_rdata[7:0] = odA_ff;
            bpo_pkg::OFS_OD_B: nxt_rdata[7:0] = odB_ff;
            default: nxt_rresp = bpo_pkg::RESP_SLVERR;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= bpo_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= nxt_rdata;
            s_axi_rresp <= nxt_rresp;
        end else if (s_axi_rvalid) begin
            s_axi_rvalid <= !s_axi_rready;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------
    // Port C pin ownership
    // ----------------------------------------
    always_comb begin
        logic odS1;
        logic odU;
        odS1 = odA_ff[bpo_pkg::SERIAL1_OPEN_DRAIN_BIT];
        odU = odB_ff[bpo_pkg::UART1_OPEN_DRAIN_BIT];
        nxt_cOe = ~cDir_ff;
        nxt_cOut = cLat_ff;
        if (ser1TwoWireEn) begin
            {nxt_cOe[3], nxt_cOut[3]} = padDrive(ser1TwoWireClkOut, 1'b1);
            {nxt_cOe[4], nxt_cOut[4]} = padDrive(ser1TwoWireDataOut, 1'b1);
        end else if (ser1SpiEn) begin
            if (!cDir_ff[3]) begin
                {nxt_cOe[3], nxt_cOut[3]} = padDrive(ser1SpiClkOut, odS1);
            end
            if (!cDir_ff[5]) begin
                {nxt_cOe[5], nxt_cOut[5]} = padDrive(ser1SpiDataOut, odS1);
            end
        end
        if (uartTxDrive) begin
            {nxt_cOe[6], nxt_cOut[6]} = padDrive(uartTxOut, odU);
        end
        if (uartDataDrive) begin
            {nxt_cOe[7], nxt_cOut[7]} = padDrive(uartDataOut, odU);
        end
    end

    // ----------------------------------------
    // Second port ownership
    // ----------------------------------------
    always_comb begin
        logic busOwns;
        logic odS2;
        busOwns = LARGE_PACKAGE && !memCtl_ff[bpo_pkg::EXT_BUS_DISABLE_BIT];
        odS2 = odA_ff[bpo_pkg::SERIAL2_OPEN_DRAIN_BIT];
        nxt_dOe = ~dDir_ff;
        nxt_dOut = dLat_ff;
        if (busOwns) begin
            nxt_dOe = {8{extBusDrive}};
            nxt_dOut = extBusOut;
        end else if (eDir_ff[bpo_pkg::PARALLEL_SLAVE_SELECT_BIT]) begin
            nxt_dOe = {8{pspDrive}};
            nxt_dOut = pspOut;
        end else if (ser2SpiEn) begin
            if (!dDir_ff[4]) begin
                {nxt_dOe[4], nxt_dOut[4]} = padDrive(ser2SpiDataOut, odS2);
            end
            if (!dDir_ff[6]) begin
                {nxt_dOe[6], nxt_dOut[6]} = padDrive(ser2SpiClkOut, odS2);
            end
        end
    end

    // ----------------------------------------
    // Pad drive and sampling
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            portCOe <= 8'h00;
            portCOut <= 8'h00;
            secondPortOe <= 8'h00;
            secondPortOut <= 8'h00;
            secondPortPullupEn <= 8'h00;
        end else begin
            portCOe <= nxt_cOe;
            portCOut <= nxt_cOut;
            secondPortOe <= nxt_dOe;
            secondPortOut <= nxt_dOut;
            secondPortPullupEn <= ~nxt_dOe & {8{~padCfg_ff[bpo_pkg::PULLUP_DISABLE_BIT]}};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            portCTwoWireBuf <= 8'h00;
            secondPortTtlBuf <= 8'h00;
        end else begin
            portCTwoWireBuf <= {3'h0, {2{ser1TwoWireEn}}, 3'h0};
            secondPortTtlBuf <= {8{eDir_ff[bpo_pkg::PARALLEL_SLAVE_SELECT_BIT]
                               || (LARGE_PACKAGE && !memCtl_ff[bpo_pkg::EXT_BUS_DISABLE_BIT])}};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cPin_ff <= 8'h00;
            dPin_ff <= 8'h00;
        end else begin
            cPin_ff <= portCIn;
            dPin_ff <= secondPortIn;
        end
    end

    // ----------------------------------------
    // Peripheral inputs
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ser1ClkIn <= 1'b0;
            ser1DataIn <= 1'b0;
            ser2ClkIn <= 1'b0;
            ser2DataIn <= 1'b0;
            uartClkIn <= 1'b0;
            uartRxIn <= 1'b0;
            extBusIn <= 8'h00;
            pspIn <= 8'h00;
        end else begin
            ser1ClkIn <= portCIn[3];
            ser1DataIn <= portCIn[4];
            ser2ClkIn <= secondPortIn[6];
            ser2DataIn <= secondPortIn[5];
            uartClkIn <= portCIn[6];
            uartRxIn <= portCIn[7];
            extBusIn <= secondPortIn;
            pspIn <= secondPortIn;
        end
    end
endmodule : bpo_port

// File: bpo_pkg.sv
// What this block does
// - Second port: eight pins, direction and latch
// - Each second-port pin has own direction bit
// - Second port normally samples through Schmitt buffers
// - Every reset makes all pins inputs
// - Weak pull-ups, one bit disables all
// - Pull-up off while pin drives
// - Pull-ups disabled after every reset
// - Large package: port usable only with bus disabled
// - Enabled memory bus owns second port, overrides direction
// - Slave port mode uses TTL input buffers
// - Serial2 SPI outputs open-drain when selected
// - Port C pin 3 carries SPI clock
// - Pin 3 two-wire clock, fixed two-wire input buffer; ser1TwoWireSmbus ignored
// - Pin 4 two-wire data or SPI input
// - Pin 5 drives SPI data when output
// - Pins 6, 7 receiver-transmitter outputs beat latch
// - Pin 7 feeds asynchronous receive via Schmitt
// - Don't-care functions ignore the direction bit
// - Direction reads return stored bits always
package bpo_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [5:0] OFS_C_PIN = 6'h00;
    localparam logic [5:0] OFS_C_LAT = 6'h04;
    localparam logic [5:0] OFS_C_DIR = 6'h08;
    localparam logic [5:0] OFS_D_PIN = 6'h0C;
    localparam logic [5:0] OFS_D_LAT = 6'h10;
    localparam logic [5:0] OFS_D_DIR = 6'h14;
    localparam logic [5:0] OFS_PAD_CFG = 6'h18;
    localparam logic [5:0] OFS_MEM_CTL = 6'h1C;
    localparam logic [5:0] OFS_E_DIR = 6'h20;
    localparam logic [5:0] OFS_OD_A = 6'h24;
    localparam logic [5:0] OFS_OD_B = 6'h28;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int PULLUP_DISABLE_BIT = 7;
    localparam int EXT_BUS_DISABLE_BIT = 7;
    localparam int PARALLEL_SLAVE_SELECT_BIT = 4;
    localparam int SERIAL2_OPEN_DRAIN_BIT = 0;
    localparam int SERIAL1_OPEN_DRAIN_BIT = 7;
    localparam int UART1_OPEN_DRAIN_BIT = 6;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_LAT = 8'h00;
    localparam logic [7:0] RST_PAD_CFG = 8'h80;
    localparam logic [7:0] RST_MEM_CTL = 8'h80;
    localparam logic [7:0] RST_E_DIR = 8'h07;
    localparam logic [7:0] RST_OD = 8'h00;
    // ----------------------------------------
    // Bus answers
    // ----------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : bpo_pkg

// File: bpo_port_assertions.sv
module bpo_port_chk #(
    parameter int PORT_WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] portCIn,
    input wire logic [7:0] portCOut,
    input wire logic [7:0] portCOe,
    input wire logic [7:0] portCTwoWireBuf,
    input wire logic [PORT_WIDTH-1:0] secondPortOe,
    input wire logic [PORT_WIDTH-1:0] secondPortPullupEn,
    input wire logic ser1SpiEn,
    input wire logic ser1TwoWireEn,
    input wire logic ser1SpiClkOut,
    input wire logic ser1SpiDataOut,
    input wire logic ser1TwoWireClkOut,
    input wire logic ser1TwoWireDataOut,
    input wire logic uartTxDrive,
    input wire logic uartTxOut,
    input wire logic uartDataDrive,
    input wire logic uartDataOut,
    input wire logic uartRxIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_spi_on;
        ser1SpiEn && !ser1TwoWireEn;
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_reset_inputs;
        $past(rst) |-> portCOe == 8'h00 && secondPortOe == '0 && secondPortPullupEn == '0;
    endproperty
    property p_pullup_off;
        (secondPortPullupEn & secondPortOe) == '0;
    endproperty
    property p_spi_clk;
        s_spi_on ##1 portCOe[3] |-> portCOut[3] == $past(ser1SpiClkOut);
    endproperty
    property p_spi_data;
        s_spi_on ##1 portCOe[5] |-> portCOut[5] == $past(ser1SpiDataOut);
    endproperty
    property p_two_wire;
        ser1TwoWireEn |=> portCTwoWireBuf[4:3] == 2'b11 && (portCOut[4:3] & portCOe[4:3]) == 2'b00
            && portCOe[3] == !$past(ser1TwoWireClkOut) && portCOe[4] == !$past(ser1TwoWireDataOut);
    endproperty
    property p_uart_tx;
        uartTxDrive |=> portCOe[6] && portCOut[6] == $past(uartTxOut);
    endproperty
    property p_uart_dt;
        uartDataDrive |=> portCOe[7] && portCOut[7] == $past(uartDataOut);
    endproperty
    property p_rx_in;
        !$past(rst) |-> uartRxIn == $past(portCIn[7]);
    endproperty
    property p_wr_resp;
        s_wr_take |-> ##[1:2] s_axi_bvalid;
    endproperty
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_rd_retire;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_reset_inputs: assert property (p_reset_inputs)
        else $error("pins not inputs after reset");
    a_pullup_off: assert property (p_pullup_off)
        else $error("pull-up on driven pin");
    a_spi_clk: assert property (p_spi_clk)
        else $error("spi clock not on pin 3");
    a_spi_data: assert property (p_spi_data)
        else $error("spi data not on pin 5");
    a_two_wire: assert property (p_two_wire)
        else $error("two-wire pins wrong");
    a_uart_tx: assert property (p_uart_tx)
        else $error("transmit not on pin 6");
    a_uart_dt: assert property (p_uart_dt)
        else $error("sync data not on pin 7");
    a_rx_in: assert property (p_rx_in)
        else $error("receive input wrong");
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response late");
    a_rd_resp: assert property (p_rd_resp)
        else $error("read response late");
    a_rd_retire: assert property (p_rd_retire)
        else $error("read response stuck");
endmodule : bpo_port_chk

bind bpo_port bpo_port_chk #(.PORT_WIDTH(PORT_WIDTH)) u_chk (.*);

// File: bpo_pad_model.sv
module bpo_pad_model #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic [W-1:0] padOut,
    input wire logic [W-1:0] padOe,
    input wire logic [W-1:0] pullEn,
    input wire logic [W-1:0] extVal,
    input wire logic [W-1:0] extDrv,
    output logic [W-1:0] padIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [W-1:0] flip_ff = '0;
    always @(posedge clk) begin
        flip_ff <= ~flip_ff;
    end
    assign padIn = (padOe & padOut) | (~padOe & extDrv & extVal) | (~padOe & ~extDrv & (pullEn | flip_ff));
endmodule : bpo_pad_model

// File: testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk = 1'b0, rst = 1'b1;
    logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, lastB;
    logic [7:0] portCIn, portCOut, portCOe, portCTwoWireBuf, extBusIn, pspIn, lat, dir;
    logic [7:0] secondPortIn, secondPortOut, secondPortOe, secondPortPullupEn, secondPortTtlBuf;
    logic ser1SpiEn = 1'b0, ser1TwoWireEn = 1'b0, ser1TwoWireSmbus = 1'b0, ser1SpiClkOut = 1'b0;
    logic ser1SpiDataOut = 1'b0, ser1TwoWireClkOut = 1'b0, ser1TwoWireDataOut = 1'b0;
    logic ser1ClkIn, ser1DataIn, ser2ClkIn, ser2DataIn, uartClkIn, uartRxIn;
    logic ser2SpiEn = 1'b0, ser2SpiClkOut = 1'b0, ser2SpiDataOut = 1'b0, extBusDrive = 1'b0, pspDrive = 1'b0;
    logic uartTxDrive = 1'b0, uartTxOut = 1'b0, uartDataDrive = 1'b0, uartDataOut = 1'b0;
    logic [7:0] extBusOut = 8'h00, pspOut = 8'h00, cExt = 8'h00, dExt = 8'h00;
    logic [31:0] seed = 32'hB43A32EC;
    logic [15:0] rstTab [9] = '{16'h0400, 16'h08FF, 16'h1000, 16'h14FF, 16'h1880, 16'h1C80, 16'h2007, 16'h2400,
        16'h2800};
    int n_fail = 0;
    int samples_checked = 0;
    always #50 clk = ~clk;
    bpo_port uut (.*);
    bpo_pad_model u_padc (.clk, .padOut(portCOut), .padOe(portCOe), .pullEn(8'h00), .extVal(cExt),
        .extDrv(8'hFF), .padIn(portCIn));
    bpo_pad_model u_padd (.clk, .padOut(secondPortOut), .padOe(secondPortOe), .pullEn(secondPortPullupEn),
        .extVal(dExt), .extDrv(8'hFF), .padIn(secondPortIn));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] pinExp(input logic [7:0] l, input logic [7:0] d, input logic [7:0] e);
        return (l & ~d) | (e & d);
    endfunction : pinExp
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task tally_and_finish;
        $display("checks=%0d fails=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    task tmo(input int i);
        if (i >= 400) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : tmo
    task stl;
        repeat (3) @(posedge clk);
        #1;
    endtask : stl
    task wr(input logic [5:0] a, input logic [7:0] d);
        int i;
        i = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, d};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            i++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready) && i < 400);
        do begin
            @(posedge clk);
            i++;
        end while (!s_axi_bvalid && i < 400);
        lastB = s_axi_bresp;
        s_axi_bready <= 1'b0;
        tmo(i);
    endtask : wr
    task rdc(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er);
        int i;
        i = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            i++;
        end while (!s_axi_arready && i < 400);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge clk);
            i++;
        end while (!s_axi_rvalid && i < 400);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h0, e});
        chk(s_axi_rresp, er);
        tmo(i);
    endtask : rdc
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 9; k++) rdc(rstTab[k][13:8], rstTab[k][7:0], bpo_pkg::RESP_OKAY);
        rdc(6'h2C, 8'h00, bpo_pkg::RESP_SLVERR);
        wr(6'h2C, 8'hFF);
        chk(lastB, bpo_pkg::RESP_SLVERR);
        wr(6'h18, 8'h00);
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            {dir, lat} = seed[15:0];
            @(posedge clk);
            cExt <= seed[23:16];
            dExt <= seed[23:16];
            wr(k[0] ? 6'h10 : 6'h04, lat);
            wr(k[0] ? 6'h14 : 6'h08, dir);
            stl;
            chk(k[0] ? secondPortOe : portCOe, 8'(~dir));
            chk((k[0] ? secondPortOut : portCOut) & ~dir, lat & ~dir);
            if (k[0]) begin
                chk(secondPortPullupEn, dir);
                chk(secondPortTtlBuf, 8'h00);
            end
            rdc(k[0] ? 6'h0C : 6'h00, pinExp(lat, dir, seed[23:16]), bpo_pkg::RESP_OKAY);
        end
        wr(6'h18, 8'h80);
        stl;
        chk(secondPortPullupEn, 8'h00);
        wr(6'h08, 8'hC7);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            @(posedge clk);
            ser1SpiEn <= 1'b1;
            ser1SpiClkOut <= seed[0];
            ser1SpiDataOut <= seed[1];
            ser1TwoWireClkOut <= seed[2];
            ser1TwoWireDataOut <= seed[3];
            ser1TwoWireSmbus <= seed[4];
            uartTxOut <= seed[5];
            uartDataOut <= seed[6];
            cExt <= seed[15:8];
            stl;
            chk({portCOe[5:3], portCOut[5], portCOut[3], ser1ClkIn}, {3'b111, seed[1:0], seed[0]});
            @(posedge clk);
            ser1SpiEn <= 1'b0;
            ser1TwoWireEn <= 1'b1;
            stl;
            chk({portCTwoWireBuf[4:3], portCOe[4:3]}, {2'b11, !seed[3], !seed[2]});
            chk({ser1DataIn, ser1ClkIn}, seed[3:2] & seed[12:11]);
            @(posedge clk);
            ser1TwoWireEn <= 1'b0;
            uartTxDrive <= 1'b1;
            uartDataDrive <= 1'b1;
            stl;
            chk({portCOe[7:6], portCOut[7:6]}, {2'b11, seed[6], seed[5]});
            rdc(6'h08, 8'hC7, bpo_pkg::RESP_OKAY);
            @(posedge clk);
            uartTxDrive <= 1'b0;
            uartDataDrive <= 1'b0;
            stl;
            chk({uartRxIn, uartClkIn, portCOe[7:6]}, {seed[15:14], 2'b00});
        end
        seed = lfsr(seed);
        wr(6'h14, 8'h00);
        @(posedge clk);
        extBusDrive <= 1'b1;
        extBusOut <= seed[7:0];
        dExt <= seed[15:8];
        stl;
        chk({secondPortOe, secondPortOut}, {8'hFF, lat});
        wr(6'h1C, 8'h00);
        stl;
        chk({secondPortOe, secondPortOut, secondPortTtlBuf}, {8'hFF, seed[7:0], 8'hFF});
        @(posedge clk);
        extBusDrive <= 1'b0;
        stl;
        chk({secondPortOe, extBusIn, ser2ClkIn, ser2DataIn}, {8'h00, seed[15:8], seed[14:13]});
        wr(6'h1C, 8'h80);
        wr(6'h20, 8'h17);
        wr(6'h14, 8'hFF);
        stl;
        chk({secondPortTtlBuf, pspIn}, {8'hFF, seed[15:8]});
        wr(6'h20, 8'h07);
        wr(6'h14, 8'h00);
        wr(6'h24, 8'h01);
        for (int b = 0; b < 2; b++) begin
            @(posedge clk);
            ser2SpiEn <= 1'b1;
            ser2SpiDataOut <= b[0];
            stl;
            chk({secondPortOe[4], secondPortOut[4] & secondPortOe[4]}, {!b[0], 1'b0});
        end
        tally_and_finish();
    end
endmodule : testbench
